/* logic/status_light_ctrl.sv */
// Status light controller with its register slave
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps

// Functional notes
// (R1) Force enable set: light follows force select only, link state ignored.
// (R2) Force select: 00 off, 01 on, 10 blink mode 1, 11 mode 2.
// (R3) Indicator set: traffic blinks always; clear: blinks only if already on.
// (R4) Full duplex on: light on while link up full duplex, no blink.
// (R5) Half duplex on: light on while link up half duplex, no blink.
// (R6) Transmit blink: mode 2 blink on link up and transmit, precondition held.
// (R7) Receive blink: mode 2 blink on link up and receive, precondition held.
// (R8) Transmit on: each transmit with link up holds light on 10 ms.
// (R9) Receive on: each receive with link up holds light on 10 ms.
// (R10) 100M on: light on while link up at 100 Mbps, no blink.
// (R11) 10M on: light on while link up at 10 Mbps, no blink.
// (R12) Collision blink: blink while link up and collision occurs.
// (R13) 100M blink: blink while link up at 100 Mbps.
// (R14) 10M blink: blink while link up at 10 Mbps.
// (R15) PHY active in link check state: light follows check select bit.
// (R16) Otherwise off; blink rates are parameters from outside.
module status_light_ctrl #(
   parameter int HOLD_CYCLES  = led_ctl_pkg::HOLD_CYC,
   parameter int BLINK1_HALF  = led_ctl_pkg::BLINK1_HALF_DEF,
   parameter int BLINK2_HALF  = led_ctl_pkg::BLINK2_HALF_DEF
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // PHY state
   input  wire logic        linkUp,
   input  wire logic        speed100,
   input  wire logic        fullDuplex,
   input  wire logic        txActive,
   input  wire logic        rxActive,
   input  wire logic        collision,
   input  wire logic        phyActive,
   input  wire logic        linkCheckState,
   // Light
   output logic             statusLight
);
   import led_ctl_pkg::*;

   logic [15:0]        ctrl_r;
   logic [31:0]        rdata_r;
   logic               ready_r;
   logic               wrPend_r;
   logic [HOLD_W-1:0]  holdCnt_r;
   logic               light_r;
   led_src_t           src_r;
   led_src_t           src_nxt;
   logic               light_nxt;
   logic               phase1;
   logic               phase2;
   logic               resp_r;
   logic [HOLD_W-1:0]  sinceTrig_r;

   logic               addrOk;
   logic               forceEn;
   logic [1:0]         forceSel;
   logic               actTrig;
   logic               holdActive;
   logic               steadyOn;
   logic               actPrecond;
   logic               actBlink;
   logic               otherBlink;
   logic               checkActive;

   // Level of the light for a given source and blink phases
   function automatic logic srcLevel(input led_src_t s,
                                     input logic p1,
                                     input logic p2);
      case (s)
         SRC_ON:     srcLevel = 1'b1;
         SRC_BLINK1: srcLevel = p1;
         SRC_BLINK2: srcLevel = p2;
         default:    srcLevel = 1'b0;
      endcase
   endfunction : srcLevel

   // Blink rates come from outside through the parameters
   blink_pacer #(
      .HALF_CYCLES (BLINK1_HALF)
   ) u_pacer1 (
      .core_clk (core_clk),
      .reset    (reset),
      .phase    (phase1)
   );

   blink_pacer #(
      .HALF_CYCLES (BLINK2_HALF)
   ) u_pacer2 (
      .core_clk (core_clk),
      .reset    (reset),
      .phase    (phase2)
   );

   // Register slave
   assign addrOk = hsel & hready & htrans[1];

   // Write data arrives one cycle after its address phase
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wrPend_r <= 1'b0;
      end else begin
         wrPend_r <= addrOk & hwrite & (haddr == CTRL_ADDR);
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl_r <= CTRL_RESET;
      end else if (wrPend_r) begin
         ctrl_r <= hwdata[15:0];
      end
   end

   // Read data prepared during the address phase, zero wait states
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rdata_r <= 32'h0000_0000;
      end else if (addrOk & ~hwrite) begin
         if (haddr == CTRL_ADDR) begin
            rdata_r <= {16'h0000, ctrl_r};
         end else if (haddr == STAT_ADDR) begin
            rdata_r <= {25'h000_0000, linkUp, holdActive, light_r, src_r};
         end else begin
            rdata_r <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ready_r <= 1'b1;
         resp_r  <= 1'b0;
      end else begin
         ready_r <= 1'b1;
         resp_r  <= 1'b0;
      end
   end

   assign hrdata    = rdata_r;
   assign hreadyout = ready_r;
   assign hresp     = resp_r;

   // Light decision
   assign forceEn  = ctrl_r[FORCE_EN_BIT];
   assign forceSel = ctrl_r[FORCE_SEL_HI:FORCE_SEL_LO];

   // Retriggered hold, so bursts of traffic keep the light lit
   assign actTrig = linkUp &
      ((ctrl_r[TX_ON_BIT] & txActive) |                   // see (R8)
       (ctrl_r[RX_ON_BIT] & rxActive));                   // see (R9)

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         holdCnt_r <= '0;
      end else if (actTrig) begin
         holdCnt_r <= HOLD_W'(HOLD_CYCLES);                // see (R8) (R9)
      end else if (holdCnt_r != '0) begin
         holdCnt_r <= holdCnt_r - 1'b1;
      end
   end

   assign holdActive = (holdCnt_r != '0);

   assign steadyOn = linkUp & (
      (ctrl_r[FDX_ON_BIT]  &  fullDuplex) |               // see (R4)
      (ctrl_r[HDX_ON_BIT]  & ~fullDuplex) |               // see (R5)
      (ctrl_r[S100_ON_BIT] &  speed100)   |               // see (R10)
      (ctrl_r[S10_ON_BIT]  & ~speed100))  | holdActive;   // see (R11)

   // Without the indicator, traffic only blinks a light already on
   assign actPrecond = ctrl_r[ACT_IND_BIT] | steadyOn;    // see (R3)

   assign actBlink = linkUp & actPrecond &
      ((ctrl_r[TX_BLK_BIT] & txActive) |                  // see (R6)
       (ctrl_r[RX_BLK_BIT] & rxActive));                  // see (R7)

   assign otherBlink = linkUp & (
      (ctrl_r[COL_BLK_BIT]  & collision) |                // see (R12)
      (ctrl_r[S100_BLK_BIT] & speed100)  |                // see (R13)
      (ctrl_r[S10_BLK_BIT]  & ~speed100));                // see (R14)

   assign checkActive = phyActive & linkCheckState;

   // Priority: force, link check, activity blink, other blink, steady
   always_comb begin
      src_nxt = SRC_OFF;                                   // see (R16)
      if (forceEn) begin
         case (forceSel)                                   // see (R1)
            FORCE_ON:     src_nxt = SRC_ON;                // see (R2)
            FORCE_BLINK1: src_nxt = SRC_BLINK1;
            FORCE_BLINK2: src_nxt = SRC_BLINK2;
            default:      src_nxt = SRC_OFF;
         endcase
      end else if (checkActive) begin
         src_nxt = ctrl_r[CHECK_LED_BIT] ? SRC_ON : SRC_OFF; // see (R15)
      end else if (actBlink) begin
         src_nxt = SRC_BLINK2;                             // see (R6) (R7)
      end else if (otherBlink) begin
         src_nxt = SRC_BLINK1;                             // see (R12)
      end else if (steadyOn) begin
         src_nxt = SRC_ON;                                 // see (R4)
      end
   end

   assign light_nxt = srcLevel(src_nxt, phase1, phase2);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         src_r <= SRC_OFF;
      end else begin
         src_r <= src_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         light_r <= 1'b0;
      end else begin
         light_r <= light_nxt;
      end
   end

   assign statusLight = light_r;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   AST_FORCE_OFF: assert property (                        // see (R1)
      forceEn && forceSel == FORCE_OFF && linkUp
      |=> !statusLight)
      else $error("forced off light is lit");

   AST_FORCE_ON: assert property (                         // see (R2)
      forceEn && forceSel == FORCE_ON |=> statusLight)
      else $error("forced on light is dark");

   AST_FORCE_BLINK: assert property (                      // see (R2)
      forceEn && forceSel == FORCE_BLINK2
      |=> statusLight == $past(phase2) && src_r == SRC_BLINK2)
      else $error("forced blink mode 2 wrong");

   AST_ACT_BLINK: assert property (                        // see (R6)
      !forceEn && !checkActive && linkUp && txActive
      && ctrl_r[TX_BLK_BIT] && ctrl_r[ACT_IND_BIT]
      |=> src_r == SRC_BLINK2)
      else $error("transmit blink not at mode 2");

   AST_ACT_GATED: assert property (                        // see (R3)
      !forceEn && !checkActive && !otherBlink && !steadyOn
      && !ctrl_r[ACT_IND_BIT] && linkUp && txActive
      && ctrl_r[TX_BLK_BIT] |=> !statusLight)
      else $error("activity blinks a dark light");

   AST_FDX_ON: assert property (                           // see (R4)
      !forceEn && !checkActive && !actBlink && !otherBlink
      && linkUp && fullDuplex && ctrl_r[FDX_ON_BIT]
      |=> statusLight)
      else $error("full duplex light not on");

   AST_HOLD: assert property (                             // see (R8)
      actTrig ##1 !actTrig |-> holdActive [*8])
      else $error("activity hold ended early");

   // Cycles since the last hold trigger, saturating; checks only
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sinceTrig_r <= '1;
      end else if (actTrig) begin
         sinceTrig_r <= '0;
      end else if (sinceTrig_r != '1) begin
         sinceTrig_r <= sinceTrig_r + 1'b1;
      end
   end

   AST_HOLD_LEN: assert property (                         // see (R8)
      sinceTrig_r < HOLD_W'(HOLD_CYCLES) |-> holdActive)
      else $error("activity hold too short");

   AST_HOLD_END: assert property (                         // see (R9)
      sinceTrig_r >= HOLD_W'(HOLD_CYCLES) |-> !holdActive)
      else $error("activity hold too long");

   AST_RX_BLINK: assert property (                         // see (R7)
      !forceEn && !checkActive && linkUp && rxActive
      && ctrl_r[RX_BLK_BIT] && (ctrl_r[ACT_IND_BIT] || steadyOn)
      |=> src_r == SRC_BLINK2)
      else $error("receive blink not at mode 2");

   AST_HDX_ON: assert property (                           // see (R5)
      !forceEn && !checkActive && !actBlink && !otherBlink
      && linkUp && !fullDuplex && ctrl_r[HDX_ON_BIT]
      |=> statusLight)
      else $error("half duplex light not on");

   AST_SPEED_ON: assert property (                         // see (R10) (R11)
      !forceEn && !checkActive && !actBlink && !otherBlink && linkUp
      && (speed100 ? ctrl_r[S100_ON_BIT] : ctrl_r[S10_ON_BIT])
      |=> statusLight)
      else $error("speed light not on");

   AST_SPEED_BLINK: assert property (                      // see (R13) (R14)
      !forceEn && !checkActive && !actBlink && linkUp
      && (speed100 ? ctrl_r[S100_BLK_BIT] : ctrl_r[S10_BLK_BIT])
      |=> src_r == SRC_BLINK1)
      else $error("speed blink not at mode 1");

   AST_COLL: assert property (                             // see (R12)
      !forceEn && !checkActive && !actBlink && linkUp
      && collision && ctrl_r[COL_BLK_BIT]
      |=> src_r == SRC_BLINK1)
      else $error("collision does not blink");

   AST_CHECK: assert property (                            // see (R15)
      !forceEn && checkActive
      |=> statusLight == $past(ctrl_r[CHECK_LED_BIT]))
      else $error("link check light wrong");

   AST_IDLE: assert property (                             // see (R16)
      !forceEn && !checkActive && !actBlink && !otherBlink
      && !steadyOn |=> !statusLight)
      else $error("light lit with nothing active");

   AST_WRITE: assert property (
      addrOk && hwrite && haddr == CTRL_ADDR
      |=> ##1 ctrl_r == $past(hwdata[15:0]))
      else $error("control write lost");

   COV_FORCE: cover property (forceEn && forceSel == FORCE_BLINK1);
   COV_ACT: cover property (actBlink ##1 !actBlink);
   COV_HOLD: cover property (actTrig ##1 holdActive && !actTrig);
   COV_CHECK: cover property (checkActive && !forceEn);
   COV_STEADY: cover property (steadyOn && !actBlink && !otherBlink);

endmodule : status_light_ctrl

/* logic/led_ctl_pkg.sv */
// Constants and types shared by the status light controller
package led_ctl_pkg;

   // Register map: registers are numbered by index, one word apart
   localparam logic [31:0] CTRL_IDX   = 32'h0000_40c0;
   // Status word is our own addition, the word after control
   localparam logic [31:0] STAT_IDX   = 32'h0000_40c1;
   localparam logic [31:0] CTRL_ADDR  = CTRL_IDX << 2;
   localparam logic [31:0] STAT_ADDR  = STAT_IDX << 2;
   localparam logic [15:0] CTRL_RESET = 16'h0311;

   // Control field positions
   localparam int FORCE_EN_BIT   = 15;
   localparam int FORCE_SEL_HI   = 14;
   localparam int FORCE_SEL_LO   = 13;
   localparam int ACT_IND_BIT    = 12;
   localparam int FDX_ON_BIT     = 11;
   localparam int HDX_ON_BIT     = 10;
   localparam int TX_BLK_BIT     = 9;
   localparam int RX_BLK_BIT     = 8;
   localparam int TX_ON_BIT      = 7;
   localparam int RX_ON_BIT      = 6;
   localparam int S100_ON_BIT    = 5;
   localparam int S10_ON_BIT     = 4;
   localparam int COL_BLK_BIT    = 3;
   localparam int S100_BLK_BIT   = 2;
   localparam int S10_BLK_BIT    = 1;
   localparam int CHECK_LED_BIT  = 0;

   // Force selections
   localparam logic [1:0] FORCE_OFF    = 2'h0;
   localparam logic [1:0] FORCE_ON     = 2'h1;
   localparam logic [1:0] FORCE_BLINK1 = 2'h2;
   localparam logic [1:0] FORCE_BLINK2 = 2'h3;

   // Bus codes
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int HOLD_TIME_NS  = 10_000_000;
   localparam int HOLD_CYC      =
      (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_W        = 22;
   localparam int BLINK_W       = 24;
   localparam int BLINK1_HALF_DEF = 12_500_000;
   localparam int BLINK2_HALF_DEF = 6_250_000;

   // Source driving the light
   typedef enum logic [3:0] {
      SRC_OFF    = 4'b0001,
      SRC_ON     = 4'b0010,
      SRC_BLINK1 = 4'b0100,
      SRC_BLINK2 = 4'b1000
   } led_src_t;

endpackage : led_ctl_pkg

/* logic/blink_pacer.sv */
// Square wave phase generator for one blink mode
`timescale 1ns/1ps

module blink_pacer #(
   parameter int HALF_CYCLES = 8
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Phase
   output logic      phase
);
   import led_ctl_pkg::*;

   logic [BLINK_W-1:0] cnt_r;
   logic               phase_r;

   // Half period counter, one toggle per half period
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_r <= '0;
      end else if (cnt_r >= BLINK_W'(HALF_CYCLES - 1)) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         phase_r <= 1'b0;
      end else if (cnt_r >= BLINK_W'(HALF_CYCLES - 1)) begin
         phase_r <= ~phase_r;
      end
   end

   assign phase = phase_r;

endmodule : blink_pacer

/* testbench/led_lamp_model.sv */
// Behavioural status lamp that counts its own transitions and lit cycles
`timescale 1ns/1ps

module led_lamp_model (
   // Clock
   input  wire logic        core_clk,
   // Lamp drive and measurement control
   input  wire logic        statusLight,
   input  wire logic        restart,
   // Measurements since the last restart
   output logic      [31:0] toggles,
   output logic      [31:0] litCycles
);
   logic prevLight;

   // Restart also takes the current level as the reference point
   always_ff @(posedge core_clk) begin
      if (restart) begin
         toggles   <= 32'h0000_0000;
         litCycles <= 32'h0000_0000;
      end else begin
         toggles   <= toggles + 32'(statusLight != prevLight);
         litCycles <= litCycles + 32'(statusLight);
      end
      prevLight <= statusLight;
   end
endmodule : led_lamp_model

/* testbench/status_light_ctrl_bench.sv */
// Self-checking bench for the status light controller
`timescale 1ns/1ps

module status_light_ctrl_bench;
   import led_ctl_pkg::*;
   // Short counts keep the run small; blink periods are 8 and 4 cycles
   localparam int HOLD = 20;
   logic        core_clk, reset, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, toggles, litCycles, rdv;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        linkUp, speed100, fullDuplex, txActive, rxActive;
   logic        collision, phyActive, linkCheckState, statusLight, restart;
   int          errTotal, checks;

   assign hready = hreadyout;

   status_light_ctrl #(.HOLD_CYCLES(HOLD), .BLINK1_HALF(4),
      .BLINK2_HALF(2)) status_light_ctrl_inst (.core_clk(core_clk),
      .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .linkUp(linkUp), .speed100(speed100), .fullDuplex(fullDuplex),
      .txActive(txActive), .rxActive(rxActive), .collision(collision),
      .phyActive(phyActive), .linkCheckState(linkCheckState),
      .statusLight(statusLight));

   led_lamp_model led_lamp_model_inst (.core_clk(core_clk),
      .statusLight(statusLight), .restart(restart), .toggles(toggles),
      .litCycles(litCycles));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, errTotal);
      if (errTotal == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errTotal++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Waits for hready at a rising edge, bounded
   task automatic waitReady();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         errTotal++;
         tally_and_finish();
      end
   endtask : waitReady

   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge core_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      waitReady();
      hsel   <= 1'b0;
      htrans <= HTRANS_IDLE;
      hwdata <= wd;
      waitReady();
      rd = hrdata;
   endtask : bus

   // Sixteen cycles: mode 1 toggles 4 times, mode 2 toggles 8 times
   task automatic observe(input int exp);
      restart <= 1'b1;
      @(posedge core_clk);
      restart <= 1'b0;
      repeat (16) @(posedge core_clk);
      #1;
      check(toggles, exp == 3 ? 32'h0000_0008 :
                     exp == 2 ? 32'h0000_0004 : 32'h0000_0000);
      if (exp < 2) check(32'(statusLight), 32'(exp));
      @(posedge core_clk);
   endtask : observe

   // Inputs are {speed100, fullDuplex, txActive, rxActive, collision}
   task automatic run(input logic [15:0] c, input logic [4:0] ins,
                      input int exp);
      bus(1'b1, CTRL_ADDR, {16'h0000, c}, rdv);
      {speed100, fullDuplex, txActive, rxActive, collision} <= ins;
      repeat (3) @(posedge core_clk);
      observe(exp);
   endtask : run

   // One activity pulse must light the lamp for the hold time only
   task automatic hold(input logic [4:0] ins);
      bus(1'b1, CTRL_ADDR, 32'h0000_00c0, rdv);
      repeat (3) @(posedge core_clk);
      restart <= 1'b1;
      {speed100, fullDuplex, txActive, rxActive, collision} <= ins;
      @(posedge core_clk);
      restart <= 1'b0;
      {speed100, fullDuplex, txActive, rxActive, collision} <= 5'b00000;
      repeat (HOLD + 8) @(posedge core_clk);
      #1;
      check(32'(litCycles >= HOLD && litCycles <= HOLD + 2), 32'd1);
      check(32'(statusLight), 32'h0000_0000);
      @(posedge core_clk);
   endtask : hold

   initial begin
      #200_000;
      errTotal++;
      tally_and_finish();
   end

   initial begin
      reset = 1'b1;
      {hsel, hwrite, restart, phyActive, linkCheckState} = 5'b00000;
      {speed100, fullDuplex, txActive, rxActive, collision} = 5'b00000;
      linkUp = 1'b1;
      haddr  = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = HTRANS_IDLE;
      hsize  = 3'h2;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      bus(1'b0, CTRL_ADDR, 32'h0000_0000, rdv);
      check(rdv, 32'h0000_0311);
      observe(1);
      run(16'h0010, 5'b00000, 1);
      run(16'h0010, 5'b10000, 0);
      run(16'h0020, 5'b10000, 1);
      run(16'h0020, 5'b00000, 0);
      run(16'h0800, 5'b01000, 1);
      run(16'h0800, 5'b00000, 0);
      run(16'h0400, 5'b00000, 1);
      run(16'h0400, 5'b01000, 0);
      run(16'h0004, 5'b10000, 2);
      run(16'h0004, 5'b00000, 0);
      run(16'h0002, 5'b00000, 2);
      run(16'h0012, 5'b00000, 2);
      run(16'h0008, 5'b00001, 2);
      run(16'h0008, 5'b00000, 0);
      run(16'h0200, 5'b00100, 0);
      run(16'h1200, 5'b00100, 3);
      // Status word: link up and the mode 2 blink source
      bus(1'b0, STAT_ADDR, 32'h0000_0000, rdv);
      check(32'({rdv[6], rdv[3:0]}), 32'({1'b1, SRC_BLINK2}));
      run(16'h0210, 5'b00100, 3);
      run(16'h1100, 5'b00010, 3);
      run(16'h0100, 5'b00010, 0);
      for (int i = 0; i < 4; i++) begin
         run({1'b1, 2'(i), 13'h1fff}, 5'b11111, i);
      end
      hold(5'b00100);
      hold(5'b00010);
      phyActive      <= 1'b1;
      run(16'h0001, 5'b00000, 0);
      linkCheckState <= 1'b1;
      run(16'h0001, 5'b00000, 1);
      run(16'h0010, 5'b00000, 0);
      phyActive      <= 1'b0;
      linkCheckState <= 1'b0;
      linkUp         <= 1'b0;
      run(16'h1ffe, 5'b11111, 0);
      bus(1'b0, STAT_ADDR, 32'h0000_0000, rdv);
      check(32'(rdv[6]), 32'h0000_0000);
      linkUp <= 1'b1;
      bus(1'b1, CTRL_ADDR, 32'hffff_ffff, rdv);
      bus(1'b0, CTRL_ADDR, 32'h0000_0000, rdv);
      check(rdv, 32'h0000_ffff);
      bus(1'b0, CTRL_ADDR + 32'h0000_0008, 32'h0000_0000, rdv);
      check(rdv, 32'h0000_0000);
      check(32'(hresp), 32'h0000_0000);
      // Reset in mid-run must restore the control defaults
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      check(32'(statusLight), 32'h0000_0000);
      reset <= 1'b0;
      bus(1'b0, CTRL_ADDR, 32'h0000_0000, rdv);
      check(rdv, 32'h0000_0311);
      tally_and_finish();
   end
endmodule : status_light_ctrl_bench
